// [smcp_map.svh]
// Opcodes, status field positions, reset values and timing counts
`ifndef SMCP_MAP_SVH
`define SMCP_MAP_SVH
`define SMCP_OP_WRITE_STATUS_CMD 8'h01
`define SMCP_OP_WRITE 8'h02
`define SMCP_OP_READ 8'h03
`define SMCP_OP_CLEAR_WRITE_LATCH_CMD 8'h04
`define SMCP_OP_READ_STATUS_CMD 8'h05
`define SMCP_OP_SET_WRITE_LATCH_CMD 8'h06
`define SMCP_OP_SLEEP 8'hB9
`define SMCP_OP_WAKE 8'hAB
`define SMCP_BIT_LOCK 7
`define SMCP_BIT_BP_HI 3
`define SMCP_BIT_BP_LO 2
`define SMCP_BIT_WEL 1
`define SMCP_STATUS_RESET 8'h00
`define SMCP_SLEEP_TIME_NS 3000
`define SMCP_WAKE_TIME_NS 400
`define SMCP_CLK_NS 20
`define SMCP_SLEEP_CYCLES ((`SMCP_SLEEP_TIME_NS + `SMCP_CLK_NS - 1) / `SMCP_CLK_NS)
`define SMCP_WAKE_CYCLES ((`SMCP_WAKE_TIME_NS + `SMCP_CLK_NS - 1) / `SMCP_CLK_NS)
`define SMCP_SCK_HALF 4
`endif

// [smcp_pkg.sv]
// Types for the two ends of the serial memory link: phases for the memory end, states for the host end
package smcp_pkg;
	typedef enum logic [2:0] {
		SMCP_PH_OPCODE,
		SMCP_PH_ADDR,
		SMCP_PH_DATA,
		SMCP_PH_STATUS,
		SMCP_PH_IGNORE
	} smcp_phase_type;
	typedef enum logic [2:0] {
		SMCP_M_IDLE,
		SMCP_M_LOAD,
		SMCP_M_LOW,
		SMCP_M_HIGH,
		SMCP_M_GAP
	} smcp_master_type;
endpackage

// [smcp_if.sv]
// Serial link between memory end and bus master end
`timescale 1ns/1ns
interface smcp_if;
	logic sck;
	logic cs_b;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic wp_b;
	modport mem (input sck, input cs_b, input mosi, input wp_b, output miso, output miso_oe);
	modport host (output sck, output cs_b, output mosi, output wp_b, input miso, input miso_oe);
endinterface

// [smcp_fifo.sv]
// Small valid/ready FIFO used in the host's transmit data path
`timescale 1ns/1ns
module smcp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	assign in_ready_out = count != (AW+1)'(DEPTH);
	assign out_valid_out = count != '0;
	assign out_data_out = mem[rd_ptr];
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data_in;
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [smcp_host.sv]
// Bus master end: issues one command per chip-select period over the link
`timescale 1ns/1ns
`include "smcp_map.svh"
module smcp_host (
	input wire logic REF_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic [7:0] CMD_OPCODE_IN,
	input wire logic [23:0] CMD_ADDR_IN,
	input wire logic [15:0] CMD_LEN_IN,
	input wire logic CMD_VALID_IN,
	output logic CMD_READY_OUT,
	input wire logic [7:0] WR_DATA_IN,
	input wire logic WR_VALID_IN,
	output logic WR_READY_OUT,
	output logic [7:0] RD_DATA_OUT,
	output logic RD_VALID_OUT,
	input wire logic WP_B_IN,
	smcp_if.host LINK
);
	smcp_pkg::smcp_master_type state;
	logic [7:0] op;
	logic [23:0] addr;
	logic [15:0] left;
	logic [5:0] hdr_bytes;
	logic [2:0] bit_cnt;
	logic [7:0] tx;
	logic [7:0] rx;
	logic [7:0] div;
	logic [7:0] gap;
	logic sck;
	logic cs_b;
	logic mosi;
	logic wp_b;
	logic miso_m;
	logic miso_s;
	logic fifo_ready;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_take;
	logic data_byte;
	wire tick = div == 8'(`SMCP_SCK_HALF - 1);
	wire last_bit = bit_cnt == 3'h7;
	wire in_hdr = hdr_bytes != '0;
	wire is_rd = op == `SMCP_OP_READ || op == `SMCP_OP_READ_STATUS_CMD;
	// R13 24-bit address
	wire has_addr = op == `SMCP_OP_READ || op == `SMCP_OP_WRITE;
	// R11 status byte follows
	wire has_data = has_addr || op == `SMCP_OP_WRITE_STATUS_CMD || op == `SMCP_OP_READ_STATUS_CMD;
	wire need_wr = !in_hdr && !is_rd;
	wire [7:0] next_tx = in_hdr ? addr[23:16] : fifo_data;
	wire [7:0] rx_next = {rx[6:0], miso_s};
	wire fifo_in_valid = WR_VALID_IN && WR_READY_OUT;
	assign fifo_take = state == smcp_pkg::SMCP_M_HIGH && tick && last_bit && left != '0 && need_wr
		&& hdr_bytes == '0 && fifo_valid;
	smcp_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
		.clk_in(REF_CLK_IN),
		.rst_b_in(RST_B_IN),
		.in_data_in(WR_DATA_IN),
		.in_valid_in(fifo_in_valid),
		.in_ready_out(fifo_ready),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_take)
	);
	assign LINK.sck = sck;
	assign LINK.cs_b = cs_b;
	assign LINK.mosi = mosi;
	assign LINK.wp_b = wp_b;
	always_ff @(posedge REF_CLK_IN) begin
		miso_m <= LINK.miso;
		miso_s <= miso_m;
		// Ready drops for a cycle after each accept, so a full FIFO is never offered
		WR_READY_OUT <= RST_B_IN && fifo_ready && !fifo_in_valid;
		wp_b <= WP_B_IN;
	end
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			state <= smcp_pkg::SMCP_M_IDLE;
			sck <= 1'b0;
			cs_b <= 1'b1;
			mosi <= 1'b0;
			CMD_READY_OUT <= 1'b0;
			RD_VALID_OUT <= 1'b0;
			RD_DATA_OUT <= 8'h00;
			div <= 8'h00;
			gap <= 8'h00;
			bit_cnt <= 3'h0;
			op <= 8'h00;
			addr <= 24'h000000;
			left <= 16'h0000;
			hdr_bytes <= 6'h00;
			tx <= 8'h00;
			rx <= 8'h00;
			data_byte <= 1'b0;
		end else begin
			RD_VALID_OUT <= 1'b0;
			div <= tick ? 8'h00 : div + 8'h01;
			case (state)
				smcp_pkg::SMCP_M_IDLE: begin
					CMD_READY_OUT <= 1'b1;
					if (CMD_VALID_IN && CMD_READY_OUT) begin
						CMD_READY_OUT <= 1'b0;
						op <= CMD_OPCODE_IN;
						addr <= CMD_ADDR_IN;
						left <= CMD_LEN_IN;
						state <= smcp_pkg::SMCP_M_LOAD;
					end
				end
				smcp_pkg::SMCP_M_LOAD: begin
					// R20 R9 opcode first
					cs_b <= 1'b0;
					tx <= {op[6:0], 1'b0};
					mosi <= op[7];
					hdr_bytes <= has_addr ? 6'h03 : 6'h00;
					if (!has_data)
						left <= 16'h0000;
					bit_cnt <= 3'h0;
					data_byte <= 1'b0;
					div <= 8'h00;
					state <= smcp_pkg::SMCP_M_LOW;
				end
				smcp_pkg::SMCP_M_LOW: if (tick) begin
					sck <= 1'b1;
					state <= smcp_pkg::SMCP_M_HIGH;
				end
				smcp_pkg::SMCP_M_HIGH: if (tick) begin
					// Sample late in the bit: the answer returns through synchronisers
					rx <= rx_next;
					if (is_rd && data_byte && last_bit) begin
						RD_VALID_OUT <= 1'b1;
						RD_DATA_OUT <= rx_next;
					end
					if (!last_bit) begin
						sck <= 1'b0;
						mosi <= tx[7];
						tx <= {tx[6:0], 1'b0};
						bit_cnt <= bit_cnt + 3'h1;
						state <= smcp_pkg::SMCP_M_LOW;
					end else if (left == '0 || (need_wr && !fifo_valid)) begin
						// R20 whole bytes only
						sck <= 1'b0;
						cs_b <= 1'b1;
						gap <= 8'h00;
						state <= smcp_pkg::SMCP_M_GAP;
					end else begin
						sck <= 1'b0;
						bit_cnt <= 3'h0;
						data_byte <= !in_hdr;
						if (in_hdr) begin
							hdr_bytes <= hdr_bytes - 6'h01;
							addr <= {addr[15:0], 8'h00};
						end else
							left <= left - 16'h0001;
						mosi <= next_tx[7];
						tx <= {next_tx[6:0], 1'b0};
						state <= smcp_pkg::SMCP_M_LOW;
					end
				end
				smcp_pkg::SMCP_M_GAP: begin
					// R19 select high gap
					gap <= gap + 8'h01;
					if (gap == 8'(`SMCP_WAKE_CYCLES))
						state <= smcp_pkg::SMCP_M_IDLE;
				end
				default: state <= smcp_pkg::SMCP_M_IDLE;
			endcase
		end
	end
endmodule

// [smcp_mem.sv]
// Memory end: command decode, protection and 128K x 8 array on the serial link
// What this block does
// R1 - Status: lock bit7, protect bits3:2, latch bit1
// R2 - Bits 6,5,4,0 stored but inert
// R3 - All status bits start at zero
// R4 - Protect pair picks none, quarter, half, all
// R5 - Latch clear blocks all array, status writes
// R6 - Lock clear: status writable regardless of pin
// R7 - Lock set: status writes need pin high
// R8 - Status read unless asleep; bit0 never set busy
// R9 - Opcode 06h alone sets the latch
// R10 - Latch cleared at power-up and 04h
// R11 - 01h plus byte loads status when allowed
// R12 - Status kept across power; latch cleared
// R13 - 24-bit address, low 17 bits decoded
// R14 - Reads stream incrementing, wrapping to zero
// R15 - Output driven only during read transfers
// R16 - Writes stream incrementing; protected bytes dropped
// R17 - Full-rate writes, no busy period
// R18 - B9h alone enters sleep after delay
// R19 - ABh wakes after recovery; host waits high
// R20 - One command per select, whole bytes
// R21 - Opcodes 01h, 02h, 03h, 04h, 05h, 06h
// R22 - Sleep B9h, wake ABh, no payload
// R23 - Modes 0 and 3; rise in, fall out
// R24 - Refused bytes skip but address advances
`timescale 1ns/1ns
`include "smcp_map.svh"
module smcp_mem #(
	parameter int AWIDTH = 17,
	parameter int SLEEP_CYCLES = `SMCP_SLEEP_CYCLES,
	parameter int WAKE_CYCLES = `SMCP_WAKE_CYCLES
) (
	input wire logic REF_CLK_IN,
	input wire logic RST_B_IN,
	output logic [7:0] STATUS_OUT,
	output logic ASLEEP_OUT,
	smcp_if.mem LINK
);
	localparam int DEPTH = 1 << AWIDTH;
	logic [7:0] array [DEPTH];
	// Status bits other than the latch survive reset (non-volatile)
	logic [7:0] status;
	// Power-up marker: low only until the first reset loads the factory value
	logic status_valid = 1'b0;
	logic sck_m, sck_s, sck_d;
	logic cs_m, cs_s, cs_d;
	logic si_m, si_s;
	logic wp_m, wp_s;
	smcp_pkg::smcp_phase_type phase;
	logic [7:0] op;
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic [1:0] addr_bytes;
	logic [AWIDTH-1:0] addr;
	logic [7:0] out_sh;
	logic miso;
	logic miso_oe;
	logic sleeping;
	logic sleep_pend;
	logic [15:0] tmr;
	wire rise = sck_s && !sck_d;
	wire fall = !sck_s && sck_d;
	wire cs_fall = !cs_s && cs_d;
	wire cs_rise = cs_s && !cs_d;
	wire [7:0] byte_in = {shreg[6:0], si_s};
	wire byte_done = rise && !cs_s && bit_cnt == 3'h7;
	// R1 status field positions
	wire write_enable_latch = status[`SMCP_BIT_WEL];
	wire [1:0] bp = {status[`SMCP_BIT_BP_HI], status[`SMCP_BIT_BP_LO]};
	// R7 status lock with pin
	wire status_ok = write_enable_latch && (!status[`SMCP_BIT_LOCK] || wp_s);
	wire [AWIDTH-1:0] next_addr = addr + 1'b1;
	wire read_live = phase == smcp_pkg::SMCP_PH_DATA && op == `SMCP_OP_READ;
	function automatic logic prot_hit(input logic [1:0] p, input logic [AWIDTH-1:0] a);
		// R4 region select from protect pair
		case (p)
			2'b01: prot_hit = a[AWIDTH-1:AWIDTH-2] == 2'b11;
			2'b10: prot_hit = a[AWIDTH-1];
			2'b11: prot_hit = 1'b1;
			default: prot_hit = 1'b0;
		endcase
	endfunction
	// R5 latch gates array writes
	wire arr_ok = write_enable_latch && !prot_hit(bp, addr);
	assign LINK.miso = miso;
	assign LINK.miso_oe = miso_oe;
	always_ff @(posedge REF_CLK_IN) begin
		sck_m <= LINK.sck;
		sck_s <= sck_m;
		sck_d <= sck_s;
		cs_m <= LINK.cs_b;
		cs_s <= cs_m;
		cs_d <= cs_s;
		si_m <= LINK.mosi;
		si_s <= si_m;
		wp_m <= LINK.wp_b;
		wp_s <= wp_m;
	end
	always_ff @(posedge REF_CLK_IN) begin
		STATUS_OUT <= status;
		ASLEEP_OUT <= sleeping;
		// R16 store each data byte, protected ones dropped
		if (byte_done && phase == smcp_pkg::SMCP_PH_DATA && op == `SMCP_OP_WRITE && arr_ok && !sleeping)
			array[addr] <= byte_in;
	end
	always_ff @(posedge REF_CLK_IN) begin
		if (!RST_B_IN) begin
			// R3 R12 latch clears at power-up, first load zero
			if (!status_valid)
				status <= `SMCP_STATUS_RESET;
			else
				status[`SMCP_BIT_WEL] <= 1'b0;
			status_valid <= 1'b1;
			phase <= smcp_pkg::SMCP_PH_OPCODE;
			op <= 8'h00;
			shreg <= 8'h00;
			bit_cnt <= 3'h0;
			addr_bytes <= 2'h0;
			addr <= '0;
			out_sh <= 8'h00;
			miso <= 1'b0;
			miso_oe <= 1'b0;
			sleeping <= 1'b0;
			sleep_pend <= 1'b0;
			tmr <= 16'h0000;
		end else begin
			if (tmr != 16'h0000)
				tmr <= tmr - 16'h0001;
			// R18 sleep reached after the fixed delay
			if (sleep_pend && tmr == 16'h0001) begin
				sleeping <= 1'b1;
				sleep_pend <= 1'b0;
			end
			// R19 wake completes after recovery
			if (!sleep_pend && sleeping && tmr == 16'h0001 && op == `SMCP_OP_WAKE)
				sleeping <= 1'b0;
			if (cs_fall) begin
				// R20 R23 new command starts on select fall
				phase <= smcp_pkg::SMCP_PH_OPCODE;
				bit_cnt <= 3'h0;
			end
			if (cs_rise) begin
				// R15 output released when select rises
				miso_oe <= 1'b0;
				if (phase == smcp_pkg::SMCP_PH_IGNORE && bit_cnt == 3'h0) begin
					// R9 R10 R22 single-byte commands act on completion
					if (op == `SMCP_OP_SET_WRITE_LATCH_CMD && !sleeping)
						status[`SMCP_BIT_WEL] <= 1'b1;
					if (op == `SMCP_OP_CLEAR_WRITE_LATCH_CMD && !sleeping)
						status[`SMCP_BIT_WEL] <= 1'b0;
					if (op == `SMCP_OP_SLEEP && !sleeping) begin
						sleep_pend <= 1'b1;
						tmr <= 16'(SLEEP_CYCLES);
					end
					if (op == `SMCP_OP_WAKE && sleeping)
						tmr <= 16'(WAKE_CYCLES);
				end
				phase <= smcp_pkg::SMCP_PH_IGNORE;
				op <= op;
			end
			if (rise && !cs_s) begin
				// R23 sample on rising edge
				shreg <= byte_in;
				bit_cnt <= bit_cnt + 3'h1;
			end
			if (byte_done) begin
				case (phase)
					smcp_pkg::SMCP_PH_OPCODE: begin
						// R21 R22 opcode decode
						op <= byte_in;
						addr_bytes <= 2'h0;
						if (sleeping && byte_in != `SMCP_OP_WAKE)
							phase <= smcp_pkg::SMCP_PH_IGNORE;
						else if (byte_in == `SMCP_OP_READ || byte_in == `SMCP_OP_WRITE)
							phase <= smcp_pkg::SMCP_PH_ADDR;
						else if (byte_in == `SMCP_OP_WRITE_STATUS_CMD || byte_in == `SMCP_OP_READ_STATUS_CMD)
							phase <= smcp_pkg::SMCP_PH_STATUS;
						else
							phase <= smcp_pkg::SMCP_PH_IGNORE;
						// R8 status read accepted at any time except while asleep
						if (byte_in == `SMCP_OP_READ_STATUS_CMD)
							out_sh <= status;
					end
					smcp_pkg::SMCP_PH_ADDR: begin
						// R13 upper address bits fall away
						addr <= {addr[AWIDTH-9:0], byte_in};
						addr_bytes <= addr_bytes + 2'h1;
						if (addr_bytes == 2'h2) begin
							phase <= smcp_pkg::SMCP_PH_DATA;
							out_sh <= array[{addr[AWIDTH-9:0], byte_in}];
						end
					end
					smcp_pkg::SMCP_PH_DATA: begin
						// R14 R17 R24 address advances, wraps, refused or not
						addr <= next_addr;
						out_sh <= array[next_addr];
					end
					smcp_pkg::SMCP_PH_STATUS: begin
						// R11 R6 R2 status load when allowed; latch untouched
						if (op == `SMCP_OP_WRITE_STATUS_CMD && status_ok)
							status <= {byte_in[7:2], status[`SMCP_BIT_WEL], byte_in[0]};
						if (op == `SMCP_OP_READ_STATUS_CMD)
							out_sh <= status;
						else
							phase <= smcp_pkg::SMCP_PH_IGNORE;
					end
					default: phase <= smcp_pkg::SMCP_PH_IGNORE;
				endcase
			end
			if (fall && !cs_s) begin
				// R15 R23 shift out on falling edge during reads
				if (read_live || (phase == smcp_pkg::SMCP_PH_STATUS && op == `SMCP_OP_READ_STATUS_CMD)) begin
					miso_oe <= 1'b1;
					miso <= out_sh[3'h7 - bit_cnt];
				end else
					miso_oe <= 1'b0;
			end
		end
	end
endmodule

// [smcp_link_chk.sv]
// Checker for framing, idle levels and output enable on the serial link
`timescale 1ns/1ns
module smcp_link_chk (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic sck_in,
	input wire logic cs_b_in,
	input wire logic mosi_in,
	input wire logic miso_in,
	input wire logic miso_oe_in
);
	logic sck_q;
	logic [15:0] bit_cnt;
	logic [7:0] op_sr;
	wire sck_rise = sck_in && !sck_q;
	wire [15:0] next_bit_cnt = cs_b_in ? 16'h0000 : (sck_rise ? bit_cnt + 16'h0001 : bit_cnt);
	wire [7:0] next_op_sr = (sck_rise && bit_cnt < 16'h0008) ? {op_sr[6:0], mosi_in} : op_sr;
	wire op_reads = (op_sr == 8'h03) || (op_sr == 8'h05);
	// Rising edges of the link clock counted per select period, opcode captured
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sck_q <= 1'b0;
			bit_cnt <= 16'h0000;
			op_sr <= 8'h00;
		end else begin
			sck_q <= sck_in;
			bit_cnt <= next_bit_cnt;
			op_sr <= next_op_sr;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence frame_start;
		$fell(cs_b_in);
	endsequence
	sequence frame_end;
		$rose(cs_b_in);
	endsequence
	// The memory sees select through two synchronisers, so release takes three cycles
	chk_oe_needs_select: assert property ((cs_b_in && $past(cs_b_in) && $past(cs_b_in, 2) && $past(cs_b_in, 3)) |-> !miso_oe_in)
		else $error("miso driven while deselected");
	chk_oe_read_only: assert property ((miso_oe_in && !cs_b_in) |-> (bit_cnt >= 16'h0008 && op_reads))
		else $error("miso driven outside a read");
	chk_sck_idle_low: assert property ((cs_b_in && $past(cs_b_in)) |-> !sck_in)
		else $error("link clock not idle low");
	chk_select_setup: assert property (frame_start |-> !sck_in [*2])
		else $error("link clock high at select fall");
	chk_mosi_stable_rise: assert property ($rose(sck_in) |-> $stable(mosi_in))
		else $error("mosi moved at clock rise");
	chk_miso_stable_rise: assert property (($rose(sck_in) && miso_oe_in && $past(miso_oe_in)) |-> $stable(miso_in))
		else $error("miso moved at clock rise");
	chk_byte_frame_end: assert property (frame_end |-> (bit_cnt[2:0] == 3'h0 && bit_cnt != 16'h0000))
		else $error("select rose off a byte boundary");
	chk_select_gap: assert property (frame_end |-> cs_b_in [*8])
		else $error("select high time too short");
endmodule

// [spi_mram_cmd_protect_tb.sv]
// Testbench joining the host and memory ends over the link
`timescale 1ns/1ns
`include "smcp_map.svh"
module spi_mram_cmd_protect_tb;
	logic REF_CLK_IN = 1'b0;
	logic RST_B_IN = 1'b0;
	logic [7:0] op = 8'h00;
	logic [23:0] addr = 24'h000000;
	logic [15:0] len = 16'h0000;
	logic cmd_valid = 1'b0;
	logic cmd_ready;
	logic [7:0] wr_data = 8'h00;
	logic wr_valid = 1'b0;
	logic wr_ready;
	logic [7:0] rd_data;
	logic rd_valid;
	logic wp_b = 1'b1;
	logic [7:0] status;
	logic asleep;
	logic [7:0] rd_q[$];
	logic [7:0] exp_mem[3];
	logic [16:0] probe[3] = '{17'h0FFFF, 17'h17FFF, 17'h18000};
	logic [17:0] prot_start[4] = '{18'h20000, 18'h18000, 18'h10000, 18'h00000};
	int fail_count = 0;
	int compares = 0;
	smcp_if link ();
	smcp_host i_smcp_host (.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .CMD_OPCODE_IN(op), .CMD_ADDR_IN(addr),
		.CMD_LEN_IN(len), .CMD_VALID_IN(cmd_valid), .CMD_READY_OUT(cmd_ready), .WR_DATA_IN(wr_data),
		.WR_VALID_IN(wr_valid), .WR_READY_OUT(wr_ready), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
		.WP_B_IN(wp_b), .LINK(link));
	smcp_mem #(.SLEEP_CYCLES(2), .WAKE_CYCLES(2)) i_smcp_mem (.REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN),
		.STATUS_OUT(status), .ASLEEP_OUT(asleep), .LINK(link));
	smcp_link_chk i_smcp_link_chk (.clk_in(REF_CLK_IN), .rst_b_in(RST_B_IN), .sck_in(link.sck),
		.cs_b_in(link.cs_b), .mosi_in(link.mosi), .miso_in(link.miso), .miso_oe_in(link.miso_oe));
	always #10 REF_CLK_IN = ~REF_CLK_IN;
	always @(posedge REF_CLK_IN) begin
		if (rd_valid === 1'b1) begin
			rd_q.push_back(rd_data);
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK_IN);
		#2;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic give_up();
		fail_count++;
		$display("CHECK FAILED handshake expected 1 seen 0");
		final_report();
	endtask
	task automatic push(input logic [7:0] d);
		int i;
		tick(1);
		wr_data = d;
		wr_valid = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge REF_CLK_IN);
			if (wr_ready === 1'b1) break;
		end
		#2;
		wr_valid = 1'b0;
		if (i == 50) give_up();
	endtask
	// Issues one command and waits until its select period is over
	task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic [15:0] n);
		int i;
		tick(1);
		op = o;
		addr = a;
		len = n;
		cmd_valid = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge REF_CLK_IN);
			if (cmd_ready === 1'b1) break;
		end
		#2;
		cmd_valid = 1'b0;
		if (i == 50) give_up();
		for (i = 0; i < 5000; i++) begin
			@(posedge REF_CLK_IN);
			if (i > 2 && link.cs_b === 1'b1) break;
		end
		if (i == 5000) give_up();
		tick(30);
	endtask
	task automatic rd(input logic [7:0] o, input logic [23:0] a, input logic [15:0] n);
		rd_q.delete();
		cmd(o, a, n);
	endtask
	task automatic wr(input logic [23:0] a, input logic [7:0] d0, input logic [7:0] d1, input logic two);
		cmd(`SMCP_OP_SET_WRITE_LATCH_CMD, 24'h000000, 16'h0000);
		push(d0);
		if (two) push(d1);
		cmd(`SMCP_OP_WRITE, a, two ? 16'h0002 : 16'h0001);
	endtask
	task automatic write_status_cmd(input logic [7:0] v);
		cmd(`SMCP_OP_SET_WRITE_LATCH_CMD, 24'h000000, 16'h0000);
		push(v);
		cmd(`SMCP_OP_WRITE_STATUS_CMD, 24'h000000, 16'h0001);
	endtask
	task automatic stat(input string name, input logic [7:0] mask, input logic [7:0] exp);
		rd(`SMCP_OP_READ_STATUS_CMD, 24'h000000, 16'h0001);
		check(name, rd_q[0] & mask, exp);
	endtask
	initial begin
		int m;
		int k;
		logic [7:0] d;
		tick(20);
		RST_B_IN = 1'b1;
		tick(3);
		stat("status after reset", 8'hFF, 8'h00);
		check("status port", status, 8'h00);
		$display("Test reset values done");
		cmd(`SMCP_OP_SET_WRITE_LATCH_CMD, 24'h000000, 16'h0000);
		stat("latch set", 8'hFF, 8'h02);
		push(8'hA5);
		push(8'h5A);
		cmd(`SMCP_OP_WRITE, 24'h000010, 16'h0002);
		cmd(`SMCP_OP_CLEAR_WRITE_LATCH_CMD, 24'h000000, 16'h0000);
		stat("latch cleared", 8'hFF, 8'h00);
		push(8'h11);
		push(8'h22);
		cmd(`SMCP_OP_WRITE, 24'h000010, 16'h0002);
		rd(`SMCP_OP_READ, 24'h000010, 16'h0002);
		check("refused byte 0", rd_q[0], 8'hA5);
		check("refused byte 1", rd_q[1], 8'h5A);
		$display("Test write latch done");
		wr(24'hFFFFFF, 8'h3C, 8'hC3, 1'b1);
		rd(`SMCP_OP_READ, 24'h01FFFF, 16'h0002);
		check("top byte", rd_q[0], 8'h3C);
		check("wrapped byte", rd_q[1], 8'hC3);
		$display("Test address wrap done");
		for (m = 0; m < 4; m++) begin
			write_status_cmd({4'h0, m[1:0], 2'b00});
			stat("protect mode", 8'hFD, {4'h0, m[1:0], 2'b00});
			for (k = 0; k < 3; k++) begin
				d = {m[3:0], k[3:0]} ^ 8'hA0;
				if ({1'b0, probe[k]} < prot_start[m]) exp_mem[k] = d;
				wr({7'h00, probe[k]}, d, 8'h00, 1'b0);
				rd(`SMCP_OP_READ, {7'h00, probe[k]}, 16'h0001);
				check("protected region", rd_q[0], exp_mem[k]);
			end
		end
		write_status_cmd(8'h74);
		stat("inert bits", 8'hFD, 8'h74);
		wr(24'h01FFFF, 8'h99, 8'h66, 1'b1);
		rd(`SMCP_OP_READ, 24'h01FFFF, 16'h0002);
		check("protected top", rd_q[0], 8'h3C);
		check("address advance", rd_q[1], 8'h66);
		$display("Test block protect done");
		RST_B_IN = 1'b0;
		tick(3);
		RST_B_IN = 1'b1;
		tick(3);
		stat("kept over reset", 8'hFF, 8'h74);
		write_status_cmd(8'h84);
		stat("lock set", 8'hFD, 8'h84);
		wp_b = 1'b0;
		write_status_cmd(8'h00);
		stat("lock held", 8'hFD, 8'h84);
		wr(24'h000020, 8'hE1, 8'h00, 1'b0);
		rd(`SMCP_OP_READ, 24'h000020, 16'h0001);
		check("array under lock", rd_q[0], 8'hE1);
		wp_b = 1'b1;
		write_status_cmd(8'h00);
		stat("lock released", 8'hFD, 8'h00);
		$display("Test status lock done");
		cmd(`SMCP_OP_SLEEP, 24'h000000, 16'h0000);
		tick(10);
		check("asleep", {7'h00, asleep}, 8'h01);
		cmd(`SMCP_OP_WAKE, 24'h000000, 16'h0000);
		tick(10);
		check("awake", {7'h00, asleep}, 8'h00);
		stat("status after wake", 8'hFD, 8'h00);
		$display("Test sleep wake done");
		final_report();
	end
endmodule
